// File: rtl/baf_defines.svh
// Constants for the binary arithmetic and flag unit
`ifndef BAF_DEFINES_SVH
`define BAF_DEFINES_SVH

// Wishbone register byte offsets
`define BAF_REG_CTRL     8'h00
`define BAF_REG_OPA      8'h04
`define BAF_REG_OPB      8'h08
`define BAF_REG_RES      8'h0c
`define BAF_REG_FLAGS    8'h10
`define BAF_REG_ADDRCHK  8'h14

// Control register fields
`define BAF_CTRL_GO      0
`define BAF_CTRL_COND    1
`define BAF_CTRL_OP_LSB  4
`define BAF_CTRL_OP_MSB  6

// Flag register bit positions (special relay bits 25404, 25405, 25504 images)
`define BAF_FLAG_OVF     0
`define BAF_FLAG_UNF     1
`define BAF_FLAG_CARRY   2
`define BAF_FLAG_EQUAL   3
`define BAF_FLAG_NEG     4
`define BAF_FLAG_ERR     5
`define BAF_FLAG_BUSY    8

// Address check fields
`define BAF_ACHK_IND     16
`define BAF_ACHK_RESET   32'h0000_0000
`define BAF_DM_LIMIT     16'h1999

// Divider iteration count
`define BAF_DIV_STEPS    16

`endif

// File: rtl/baf_pkg.sv
// Types for the binary arithmetic and flag unit
`default_nettype none
package baf_pkg;
    typedef enum logic [2:0] {
        BAF_OP_DIVU  = 3'h0,
        BAF_OP_ADDL  = 3'h1,
        BAF_OP_SUBL  = 3'h2,
        BAF_OP_MULS  = 3'h3,
        BAF_OP_ADDW  = 3'h4
    } baf_op_e;

    typedef enum logic [1:0] {
        BAF_ST_IDLE = 2'b00,
        BAF_ST_DIV  = 2'b01,
        BAF_ST_DONE = 2'b11
    } baf_state_e;

    typedef struct packed {
        logic error_flag;
        logic negative_flag;
        logic equal_flag;
        logic carry_flag;
        logic underflow_flag;
        logic overflow_flag;
    } baf_flags_s;
endpackage
`default_nettype wire

// File: rtl/baf_divider.sv
// Iterative 16-bit unsigned restoring divider
`default_nettype none
`include "baf_defines.svh"
module baf_divider #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             start_i,
    input  wire logic [WIDTH-1:0] dividend_word_i,
    input  wire logic [WIDTH-1:0] divisor_word_i,
    output logic                  done_o,
    output logic      [WIDTH-1:0] quotient_o,
    output logic      [WIDTH-1:0] remainder_o
);
    if (WIDTH != `BAF_DIV_STEPS) begin : g_width_check
        $error("baf_divider: WIDTH must equal step count");
    end

    logic [WIDTH-1:0] quo_q;
    logic [WIDTH:0]   rem_q;
    logic [WIDTH-1:0] dvs_q;
    logic [4:0]       cnt_q;
    logic             run_q;
    logic [WIDTH:0]   trial;

    assign trial       = {rem_q[WIDTH-1:0], quo_q[WIDTH-1]} - {1'b0, dvs_q};
    assign quotient_o  = quo_q;
    assign remainder_o = rem_q[WIDTH-1:0];

    // One quotient bit per cycle keeps the unit small at the cost of latency
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quo_q  <= '0;
            rem_q  <= '0;
            dvs_q  <= '0;
            cnt_q  <= 5'h00;
            run_q  <= 1'b0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (start_i && !run_q) begin
                quo_q <= dividend_word_i;
                rem_q <= '0;
                dvs_q <= divisor_word_i;
                cnt_q <= 5'h00;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (!trial[WIDTH]) begin
                    rem_q <= trial;
                    quo_q <= {quo_q[WIDTH-2:0], 1'b1};
                end else begin
                    rem_q <= {rem_q[WIDTH-1:0], quo_q[WIDTH-1]};
                    quo_q <= {quo_q[WIDTH-2:0], 1'b0};
                end
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q == 5'(WIDTH - 1)) begin
                    run_q  <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule // baf_divider
`default_nettype wire

// File: rtl/baf_unit.sv
// Binary arithmetic datapath with condition flags, Wishbone slave
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`default_nettype none
`include "baf_defines.svh"
// How it works
// - Condition low means no operation; results and flags stay as they were.
// - Unsigned divide puts quotient in first word, remainder in second.
// - Divide and double add copy first result word bit 15 to negative.
// - Bad BCD indirect address or address past area end raises error.
// - Double add sums two 32-bit values plus carry; low word first.
// - Double add carry set when the sum passes FFFF FFFF, else cleared.
// - Double add and subtract flag overflow above 7FFF FFFF signed.
// - Double add and subtract flag underflow below 8000 0000 signed.
// - Equal flag set when divide quotient or add or subtract result is zero.
// - Double subtract takes subtrahend and carry from minuend; low word first.
// - Negative difference sets carry and stores its two's complement form.
// - Subtract carry set exactly when minuend is below subtrahend plus carry.
// - Subtract and multiply copy second result word bit 15 to negative.
// - Signed multiply of two 16-bit words, low half first, high half next.
// - Multiply equal flag set only for an all-zero 32-bit product.
// - Overflow, underflow and carry sit at fixed bits of the flag register.
// - Signed 32-bit values use two's complement over the full range.
// - Single-word add sets carry when the sum passes FFFF.
module baf_unit (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    output logic      [15:0] result_lo_o,
    output logic      [15:0] result_hi_o,
    output baf_pkg::baf_flags_s flags_o,
    output logic             busy_o
);
    // ********************************
    // Bus slave
    // ********************************
    logic [31:0] ctrl_q;
    logic [31:0] opa_q;
    logic [31:0] opb_q;
    logic [31:0] achk_q;
    logic        go_q;
    logic        req;
    logic        wr;
    logic        known;
    logic [31:0] rdata;

    baf_pkg::baf_flags_s flags_q;
    baf_pkg::baf_state_e st_q;
    logic [15:0]         res_lo_q;
    logic [15:0]         res_hi_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        logic k;
        k = 1'b0;
        if (a == `BAF_REG_CTRL) k = 1'b1;
        else if (a == `BAF_REG_OPA) k = 1'b1;
        else if (a == `BAF_REG_OPB) k = 1'b1;
        else if (a == `BAF_REG_RES) k = 1'b1;
        else if (a == `BAF_REG_FLAGS) k = 1'b1;
        else if (a == `BAF_REG_ADDRCHK) k = 1'b1;
        return k;
    endfunction

    assign req   = cyc_i && stb_i && !ack_o && !err_o;
    assign known = addr_known(adr_i);
    assign wr    = req && we_i && known && ce_i;

    always_comb begin
        rdata = 32'h0000_0000;
        if (adr_i == `BAF_REG_CTRL) rdata = ctrl_q;
        else if (adr_i == `BAF_REG_OPA) rdata = opa_q;
        else if (adr_i == `BAF_REG_OPB) rdata = opb_q;
        else if (adr_i == `BAF_REG_RES) rdata = {res_hi_q, res_lo_q};
        else if (adr_i == `BAF_REG_FLAGS) rdata = {23'h000000, busy_o, 2'h0, flags_q};
        else if (adr_i == `BAF_REG_ADDRCHK) rdata = achk_q;
    end

    // Ack or error one cycle after the request; dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_o <= req && known;
            err_o <= req && !known;
            if (req && !we_i) dat_o <= rdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 32'h0000_0000;
            opa_q  <= 32'h0000_0000;
            opb_q  <= 32'h0000_0000;
            achk_q <= `BAF_ACHK_RESET;
        end else if (wr) begin
            if (adr_i == `BAF_REG_CTRL) ctrl_q <= merge(ctrl_q, dat_i, sel_i) & 32'hffff_fffe;
            else if (adr_i == `BAF_REG_OPA) opa_q <= merge(opa_q, dat_i, sel_i);
            else if (adr_i == `BAF_REG_OPB) opb_q <= merge(opb_q, dat_i, sel_i);
            else if (adr_i == `BAF_REG_ADDRCHK) achk_q <= merge(achk_q, dat_i, sel_i);
        end
    end

    // Go is a pulse; a go bit written while busy is dropped, the rest of the write is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) go_q <= 1'b0;
        else if (ce_i) go_q <= wr && adr_i == `BAF_REG_CTRL && sel_i[0] && dat_i[`BAF_CTRL_GO]
                               && st_q == baf_pkg::BAF_ST_IDLE;
    end

    // ********************************
    // Arithmetic
    // ********************************
    baf_pkg::baf_op_e op;
    logic        cond;
    logic        cin;
    logic [32:0] add_full;
    logic [32:0] sub_full;
    logic [16:0] addw_full;
    logic [31:0] prod;
    logic        add_ov;
    logic        add_un;
    logic        sub_ov;
    logic        sub_un;
    logic        addr_bad;
    logic        div_start;
    logic        div_done;
    logic [15:0] div_quo;
    logic [15:0] div_rem;

    assign op   = baf_pkg::baf_op_e'(ctrl_q[`BAF_CTRL_OP_MSB:`BAF_CTRL_OP_LSB]);
    assign cond = ctrl_q[`BAF_CTRL_COND];
    assign cin  = flags_q.carry_flag;

    function automatic logic bcd_ok(input logic [15:0] w);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (w[i*4 +: 4] > 4'h9) ok = 1'b0;
        end
        return ok;
    endfunction

    // Indirect address check on the word given in the check register
    assign addr_bad = achk_q[`BAF_ACHK_IND] && (!bcd_ok(achk_q[15:0]) || achk_q[15:0] > `BAF_DM_LIMIT);

    assign add_full  = {1'b0, opa_q} + {1'b0, opb_q} + {32'h0000_0000, cin};
    assign sub_full  = {1'b0, opa_q} - {1'b0, opb_q} - {32'h0000_0000, cin};
    assign addw_full = {1'b0, opa_q[15:0]} + {1'b0, opb_q[15:0]} + {16'h0000, cin};
    // Operands widened first so the product keeps all 32 bits
    assign prod      = $signed({{16{opa_q[15]}}, opa_q[15:0]}) * $signed({{16{opb_q[15]}}, opb_q[15:0]});
    // Sign-based range tests on the wrapped 32-bit result
    assign add_ov = !opa_q[31] && !opb_q[31] && add_full[31];
    assign add_un = opa_q[31] && opb_q[31] && !add_full[31];
    assign sub_ov = !opa_q[31] && opb_q[31] && sub_full[31];
    assign sub_un = opa_q[31] && !opb_q[31] && !sub_full[31];

    assign div_start = go_q && cond && op == baf_pkg::BAF_OP_DIVU && opb_q[15:0] != 16'h0000 && !addr_bad;

    baf_divider #(
        .WIDTH(16)
    ) u_div (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .ce_i           (ce_i),
        .start_i        (div_start),
        .dividend_word_i(opa_q[15:0]),
        .divisor_word_i (opb_q[15:0]),
        .done_o         (div_done),
        .quotient_o     (div_quo),
        .remainder_o    (div_rem)
    );

    // ********************************
    // Sequencer and result update
    // ********************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= baf_pkg::BAF_ST_IDLE;
        end else if (ce_i) begin
            case (st_q)
                baf_pkg::BAF_ST_IDLE: if (div_start) st_q <= baf_pkg::BAF_ST_DIV;
                baf_pkg::BAF_ST_DIV:  if (div_done) st_q <= baf_pkg::BAF_ST_DONE;
                baf_pkg::BAF_ST_DONE: st_q <= baf_pkg::BAF_ST_IDLE;
                default:              st_q <= baf_pkg::BAF_ST_IDLE;
            endcase
        end
    end

    assign busy_o = st_q != baf_pkg::BAF_ST_IDLE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_lo_q <= 16'h0000;
            res_hi_q <= 16'h0000;
            flags_q  <= '0;
        end else if (ce_i) begin
            if (div_done) begin
                res_lo_q               <= div_quo;
                res_hi_q               <= div_rem;
                flags_q.error_flag     <= 1'b0;
                flags_q.equal_flag     <= div_quo == 16'h0000;
                flags_q.negative_flag  <= div_quo[15];
            end else if (go_q && cond) begin
                if (addr_bad) begin
                    flags_q.error_flag <= 1'b1;
                end else begin
                    case (op)
                        baf_pkg::BAF_OP_DIVU: begin
                            if (opb_q[15:0] == 16'h0000) flags_q.error_flag <= 1'b1;
                        end
                        baf_pkg::BAF_OP_ADDL: begin
                            {res_hi_q, res_lo_q}   <= add_full[31:0];
                            flags_q.carry_flag     <= add_full[32];
                            flags_q.overflow_flag  <= add_ov;
                            flags_q.underflow_flag <= add_un;
                            flags_q.equal_flag     <= add_full[31:0] == 32'h0000_0000;
                            flags_q.negative_flag  <= add_full[15];
                            flags_q.error_flag     <= 1'b0;
                        end
                        baf_pkg::BAF_OP_SUBL: begin
                            {res_hi_q, res_lo_q}   <= sub_full[31:0];
                            flags_q.carry_flag     <= sub_full[32];
                            flags_q.overflow_flag  <= sub_ov;
                            flags_q.underflow_flag <= sub_un;
                            flags_q.equal_flag     <= sub_full[31:0] == 32'h0000_0000;
                            flags_q.negative_flag  <= sub_full[31];
                            flags_q.error_flag     <= 1'b0;
                        end
                        baf_pkg::BAF_OP_MULS: begin
                            {res_hi_q, res_lo_q}   <= prod;
                            flags_q.equal_flag     <= prod == 32'h0000_0000;
                            flags_q.negative_flag  <= prod[31];
                            flags_q.error_flag     <= 1'b0;
                        end
                        baf_pkg::BAF_OP_ADDW: begin
                            res_lo_q               <= addw_full[15:0];
                            flags_q.carry_flag     <= addw_full[16];
                            flags_q.equal_flag     <= addw_full[15:0] == 16'h0000;
                            flags_q.negative_flag  <= addw_full[15];
                            flags_q.error_flag     <= 1'b0;
                        end
                        default: flags_q.error_flag <= 1'b1;
                    endcase
                end
            end
        end
    end

    // Flag bits live at fixed positions of the flag register
    assign flags_o     = flags_q;
    assign result_lo_o = res_lo_q;
    assign result_hi_o = res_hi_q;

    // ********************************
    // Checks
    // ********************************
    // Operation that really executes at this edge
    logic run_now;
    assign run_now = ce_i && go_q && cond && !addr_bad;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_NOCOND_HOLD: assert property (ce_i && go_q && !cond |=> $stable({res_hi_q, res_lo_q}) && $stable(flags_q))
        else $error("Result changed without execution condition");
    // Divide takes one edge to load and sixteen to iterate
    AST_DIV_LATENCY: assert property (disable iff (rst_i || !ce_i) div_start |-> ##17 div_done)
        else $error("Divide did not finish in time");
    AST_DIV_RESULT: assert property (ce_i && div_done |=> res_lo_q == $past(div_quo) && res_hi_q == $past(div_rem))
        else $error("Quotient not stored");
    AST_DIV_ZERO: assert property (ce_i && go_q && cond && !addr_bad && op == baf_pkg::BAF_OP_DIVU && opb_q[15:0] == 16'h0000
        |=> flags_q.error_flag && $stable({res_hi_q, res_lo_q}))
        else $error("Zero divisor not flagged");
    AST_ADD_CARRY: assert property (ce_i && go_q && cond && !addr_bad && op == baf_pkg::BAF_OP_ADDL
        |=> flags_q.carry_flag == $past(add_full[32]) && flags_q.negative_flag == res_lo_q[15])
        else $error("Double add carry wrong");
    AST_SUB_CARRY: assert property (ce_i && go_q && cond && !addr_bad && op == baf_pkg::BAF_OP_SUBL
        |=> flags_q.carry_flag == ($past({1'b0, opa_q}) < $past({1'b0, opb_q}) + 33'($past(cin))))
        else $error("Double subtract borrow wrong");
    AST_SUB_NEG: assert property (ce_i && go_q && cond && !addr_bad && op == baf_pkg::BAF_OP_SUBL
        |=> flags_q.negative_flag == res_hi_q[15])
        else $error("Subtract negative flag wrong");
    AST_OVF_RANGE: assert property (ce_i && go_q && cond && !addr_bad && op == baf_pkg::BAF_OP_ADDL
        |=> flags_q.overflow_flag == ($past(add_ov)) && !(flags_q.overflow_flag && flags_q.underflow_flag))
        else $error("Overflow flag wrong");
    AST_MUL_EQ: assert property (ce_i && go_q && cond && !addr_bad && op == baf_pkg::BAF_OP_MULS
        |=> flags_q.equal_flag == ({res_hi_q, res_lo_q} == 32'h0000_0000))
        else $error("Multiply equal flag wrong");
    AST_BAD_ADDR: assert property (ce_i && go_q && cond && addr_bad |=> flags_q.error_flag)
        else $error("Bad address not flagged");

    // Results and flags against their arithmetic definitions
    AST_ADD_SUM: assert property (run_now && op == baf_pkg::BAF_OP_ADDL
        |=> {res_hi_q, res_lo_q} == $past(opa_q) + $past(opb_q) + 32'($past(cin)))
        else $error("Double add sum wrong");
    AST_SUB_DIFF: assert property (run_now && op == baf_pkg::BAF_OP_SUBL
        |=> {res_hi_q, res_lo_q} == $past(opa_q) - $past(opb_q) - 32'($past(cin)))
        else $error("Double subtract difference wrong");
    AST_EQ_ZERO: assert property (run_now && (op == baf_pkg::BAF_OP_ADDL || op == baf_pkg::BAF_OP_SUBL)
        |=> flags_q.equal_flag == ({res_hi_q, res_lo_q} == 32'h0000_0000))
        else $error("Equal flag does not match zero result");
    AST_SUB_RANGE: assert property (run_now && op == baf_pkg::BAF_OP_SUBL
        |=> flags_q.overflow_flag == $past(sub_ov) && flags_q.underflow_flag == $past(sub_un))
        else $error("Subtract range flags wrong");
    AST_ADDW_CARRY: assert property (run_now && op == baf_pkg::BAF_OP_ADDW
        |=> flags_q.carry_flag == ($past(opa_q[15:0]) + $past(opb_q[15:0]) + 17'($past(cin)) > 17'h0_ffff))
        else $error("Single add carry wrong");
    AST_DIV_FLAGS: assert property (ce_i && div_done
        |=> flags_q.negative_flag == res_lo_q[15] && flags_q.equal_flag == (res_lo_q == 16'h0000))
        else $error("Divide flags wrong");
    AST_MUL_NEG: assert property (run_now && op == baf_pkg::BAF_OP_MULS
        |=> flags_q.negative_flag == res_hi_q[15])
        else $error("Multiply negative flag wrong");
    AST_ACK_PULSE: assert property (ce_i && ack_o |=> !ack_o)
        else $error("Acknowledge held longer than one cycle");
    AST_ERR_PULSE: assert property (ce_i && err_o |=> !err_o)
        else $error("Bus error held longer than one cycle");

    // Main scenarios worth seeing in a run
    COV_DIV: cover property (div_done);
    COV_DIV_ZERO: cover property (run_now && op == baf_pkg::BAF_OP_DIVU && opb_q[15:0] == 16'h0000);
    COV_SUB_NEG: cover property (ce_i && go_q && cond && op == baf_pkg::BAF_OP_SUBL && sub_full[32]);
    COV_ADD_OVF: cover property (ce_i && go_q && cond && op == baf_pkg::BAF_OP_ADDL && add_ov);
    COV_MUL_NEG: cover property (ce_i && go_q && cond && op == baf_pkg::BAF_OP_MULS && prod[31]);
endmodule // baf_unit
`default_nettype wire

// File: tb/baf_seq_model.sv
// Sequencer model: classic Wishbone master feeding the arithmetic unit
`default_nettype none
module baf_seq_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic        err_i,
    input  wire logic [31:0] dat_i,
    output var  logic        cyc_o,
    output var  logic        stb_o,
    output var  logic        we_o,
    output var  logic [7:0]  adr_o,
    output var  logic [3:0]  sel_o,
    output var  logic [31:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        adr_o <= 8'h00;
        sel_o <= 4'hf;
        dat_o <= 32'h0000_0000;
    end
    // ****************************************
    // One single cycle; waits up to 50 clocks for ack or error
    // ****************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output bit to);
        int n;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= d;
        to = 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (ack_i === 1'b1 || err_i === 1'b1) begin
                to = 1'b0;
                break;
            end
        end
        q = dat_i;
        e = err_i;
        // Released lines show the inverse so a stale value never passes
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        adr_o <= ~a;
        dat_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule // baf_seq_model
`default_nettype wire

// File: tb/baf_unit_tb.sv
// Self-checking bench for the arithmetic and flag unit
`default_nettype none
`include "baf_defines.svh"
module baf_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic        ack, err, busy;
    logic [15:0] res_lo, res_hi;
    baf_pkg::baf_flags_s flags;
    int          errors = 0;
    int          checks_done = 0;
    logic [31:0] q;
    logic        e;
    always #10 clk_i = ~clk_i;
    baf_seq_model i_seq (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
                         .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    baf_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
                    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
                    .result_lo_o(res_lo), .result_hi_o(res_hi), .flags_o(flags), .busy_o(busy));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        bit to;
        i_seq.xfer(w, a, d, q, e, to);
        if (to) begin
            errors++;
            $display("[ERR] bus answer timed out");
            wrap_up();
        end
    endtask
    // Runs one operation; rm and fm hide fields that the op leaves undefined
    task automatic run_op(input logic [2:0] op, input logic c, input logic [31:0] a, input logic [31:0] b,
                          input logic [31:0] res, input logic [31:0] rm, input logic [5:0] fl,
                          input logic [5:0] fm);
        int n;
        logic exp_busy;
        exp_busy = op == baf_pkg::BAF_OP_DIVU && c && b[15:0] != 16'h0000;
        acc(1'b1, `BAF_REG_OPA, a);
        acc(1'b1, `BAF_REG_OPB, b);
        acc(1'b1, `BAF_REG_CTRL, {25'h0, op, 2'b00, c, 1'b1});
        acc(1'b0, `BAF_REG_FLAGS, 32'h0);
        chk("busy_start", {31'h0, exp_busy}, {31'h0, q[`BAF_FLAG_BUSY]});
        for (n = 0; n < 60 && q[`BAF_FLAG_BUSY] !== 1'b0; n++) begin
            acc(1'b0, `BAF_REG_FLAGS, 32'h0);
        end
        chk("busy", 32'h0, {31'h0, q[`BAF_FLAG_BUSY]});
        chk("busy_pin", 32'h0, {31'h0, busy});
        if (q[`BAF_FLAG_BUSY] !== 1'b0) wrap_up();
        acc(1'b0, `BAF_REG_RES, 32'h0);
        chk("res", res & rm, q & rm);
        chk("res_pins", res & rm, {res_hi, res_lo} & rm);
        acc(1'b0, `BAF_REG_FLAGS, 32'h0);
        chk("flags", {26'h0, fl & fm}, q & {26'h0, fm});
        chk("flag_pins", q & 32'h3f, {26'h0, flags});
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(1'b0, `BAF_REG_RES, 32'h0);
        chk("res_reset", 32'h0, q);
        acc(1'b0, `BAF_REG_FLAGS, 32'h0);
        chk("flags_reset", 32'h0, q);
        acc(1'b0, `BAF_REG_ADDRCHK, 32'h0);
        chk("achk_reset", `BAF_ACHK_RESET, q);
        run_op(baf_pkg::BAF_OP_ADDL, 1'b1, 32'h6b3c_167d, 32'hef25_8c47, 32'h5a61_a2c4, '1, 6'h14, 6'h3f);
        run_op(baf_pkg::BAF_OP_SUBL, 1'b1, 32'h6b3c_167d, 32'hef25_8c47, 32'h7c16_8a35, '1, 6'h04, 6'h3f);
        run_op(baf_pkg::BAF_OP_SUBL, 1'b1, 32'h8000_0000, 32'h0, 32'h7fff_ffff, '1, 6'h02, 6'h3f);
        run_op(baf_pkg::BAF_OP_ADDL, 1'b1, 32'h7fff_ffff, 32'h1, 32'h8000_0000, '1, 6'h01, 6'h3f);
        run_op(baf_pkg::BAF_OP_SUBL, 1'b1, 32'h7fff_ffff, 32'hffff_ffff, 32'h8000_0000, '1, 6'h15, 6'h3f);
        run_op(baf_pkg::BAF_OP_SUBL, 1'b1, 32'h1, 32'h0, 32'h0, '1, 6'h08, 6'h3f);
        run_op(baf_pkg::BAF_OP_ADDL, 1'b1, 32'hffff_ffff, 32'h1, 32'h0, '1, 6'h0c, 6'h3f);
        run_op(baf_pkg::BAF_OP_ADDL, 1'b0, 32'h5, 32'h6, 32'h0, '1, 6'h0c, 6'h3f);
        run_op(baf_pkg::BAF_OP_SUBL, 1'b0, 32'h9, 32'h3, 32'h0, '1, 6'h0c, 6'h3f);
        run_op(baf_pkg::BAF_OP_DIVU, 1'b0, 32'h9, 32'h3, 32'h0, '1, 6'h0c, 6'h3f);
        run_op(baf_pkg::BAF_OP_ADDW, 1'b1, 32'hffff, 32'h1, 32'h1, 32'hffff, 6'h04, 6'h04);
        run_op(baf_pkg::BAF_OP_DIVU, 1'b1, 32'h1234_f8c5, 32'h10, 32'h0005_0f8c, '1, 6'h00, 6'h38);
        run_op(baf_pkg::BAF_OP_DIVU, 1'b1, 32'h8000, 32'h1, 32'h0000_8000, '1, 6'h10, 6'h38);
        run_op(baf_pkg::BAF_OP_DIVU, 1'b1, 32'h5, 32'h7, 32'h0005_0000, '1, 6'h08, 6'h38);
        run_op(baf_pkg::BAF_OP_DIVU, 1'b1, 32'h9, 32'h0, 32'h0005_0000, '1, 6'h28, 6'h38);
        run_op(baf_pkg::BAF_OP_MULS, 1'b1, 32'hfffe, 32'h3, 32'hffff_fffa, '1, 6'h10, 6'h38);
        run_op(baf_pkg::BAF_OP_MULS, 1'b1, 32'h8000, 32'h8000, 32'h4000_0000, '1, 6'h00, 6'h38);
        run_op(baf_pkg::BAF_OP_MULS, 1'b1, 32'h0, 32'h1234, 32'h0, '1, 6'h08, 6'h38);
        // Out-of-area and non-BCD indirect words both block the op
        acc(1'b1, `BAF_REG_ADDRCHK, 32'h0001_2000);
        run_op(baf_pkg::BAF_OP_MULS, 1'b1, 32'h2, 32'h3, 32'h0, '1, 6'h20, 6'h20);
        acc(1'b1, `BAF_REG_ADDRCHK, 32'h0001_00a0);
        run_op(baf_pkg::BAF_OP_MULS, 1'b1, 32'h2, 32'h3, 32'h0, '1, 6'h20, 6'h20);
        acc(1'b1, `BAF_REG_ADDRCHK, 32'h0001_1999);
        run_op(baf_pkg::BAF_OP_MULS, 1'b1, 32'h2, 32'h3, 32'h6, '1, 6'h00, 6'h20);
        acc(1'b0, 8'h18, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, e});
        acc(1'b1, 8'h18, 32'hdead_beef);
        chk("unmapped_wr_err", 32'h1, {31'h0, e});
        acc(1'b1, `BAF_REG_RES, 32'hdead_beef);
        acc(1'b0, `BAF_REG_RES, 32'h0);
        chk("res_readonly", 32'h6, q);
        wrap_up();
    end
endmodule // baf_unit_tb
`default_nettype wire
